// file: bots_branch.sv
// startup delay and shutdown lag sequencer of one branch output
`timescale 1ns/100ps
module bots_branch
   import bots_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic tick,
   input wire logic start,
   input wire logic test_on,
   input wire logic trip_en,
   input wire logic seq_en,
   input wire logic trip,
   input wire bots_timing_s timing,
   output logic connected,
   output logic cut,
   output logic cut_evt
);

   bots_br_e state_reg;
   logic [DLY_W-1:0] cnt_reg;

   // ****************************************
   // branch state
   // ****************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg <= BR_IDLE;
         cnt_reg <= DLY_RST;
      end else begin
         case (state_reg)
            BR_IDLE: begin
               cnt_reg <= DLY_RST;
               if (start && test_on && !(trip && trip_en)) begin
                  state_reg <= BR_DELAY;
               end
            end
            BR_DELAY: begin
               if (!test_on) begin
                  state_reg <= BR_IDLE;
               end else if (trip && trip_en) begin
                  state_reg <= BR_CUT;
               end else if (cnt_reg >= timing.on_delay) begin
                  state_reg <= BR_ON;
               end else if (tick) begin
                  cnt_reg <= cnt_reg + 16'h0001;
               end
            end
            BR_ON: begin
               cnt_reg <= DLY_RST;
               if (!test_on) begin
                  state_reg <= BR_IDLE;
               end else if (trip && trip_en) begin
                  // a disabled branch ignores the trip input in every state except the cut state, which it leaves only once the trip is released
                  if (seq_en && timing.off_lag != DLY_RST) begin
                     state_reg <= BR_LAG;
                  end else begin
                     state_reg <= BR_CUT;
                  end
               end
            end
            BR_LAG: begin
               if (cnt_reg >= timing.off_lag) begin
                  state_reg <= BR_CUT;
               end else if (tick) begin
                  cnt_reg <= cnt_reg + 16'h0001;
               end
            end
            BR_CUT: begin
               cnt_reg <= DLY_RST;
               // released trip restarts the startup delay, never an instant reconnect
               if (!trip) begin
                  state_reg <= BR_IDLE;
               end
            end
            default: begin
               state_reg <= BR_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cut_evt <= 1'b0;
      end else begin
         cut_evt <= (state_reg != BR_CUT) && (state_reg != BR_IDLE) && trip && trip_en
            && !(state_reg == BR_ON && seq_en && timing.off_lag != DLY_RST)
            && !(state_reg == BR_LAG && cnt_reg < timing.off_lag);
      end
   end

   assign connected = (state_reg == BR_ON) || (state_reg == BR_LAG);
   assign cut = (state_reg == BR_CUT);

endmodule // bots_branch

// file: bots_pkg.sv
// constants, types and register map of the branch output trip sequencer
package bots_pkg;

   // ****************************************
   // sizes and timing
   // ****************************************
   localparam int NUM_BRANCH = 4;
   localparam int DLY_W = 16;
   localparam int ADDR_W = 8;
   localparam int CLK_PERIOD_NS = 10;
   localparam int TICK_TIME_US = 1000;
   localparam int TICK_CYCLES_DEF = (TICK_TIME_US * 1000) / CLK_PERIOD_NS;

   // ****************************************
   // register offsets
   // ****************************************
   localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_PROT = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_TEMP_SET = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_RUN_THR = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_IRQ_CLR = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_IRQ_EN = 8'h1C;
   localparam logic [ADDR_W-1:0] OFS_ON_DLY = 8'h20;
   localparam logic [ADDR_W-1:0] OFS_OFF_LAG = 8'h30;

   // ****************************************
   // reset values, top protection level and temperature hysteresis
   // ****************************************
   localparam logic [1:0] PROT_RST = 2'h1;
   localparam logic [1:0] PROT_MAX = 2'h2;
   localparam logic [7:0] TEMP_SET_RST = 8'h55;
   localparam logic [7:0] TEMP_HYST = 8'h03;
   localparam logic [15:0] RUN_THR_RST = 16'h0000;
   localparam logic [15:0] DLY_RST = 16'h0000;

   // ****************************************
   // field positions
   // ****************************************
   localparam int CTRL_TEST_LSB = 0;
   localparam int CTRL_TRIPEN_LSB = 4;
   localparam int CTRL_SEQ_BIT = 8;
   localparam int ST_TEMP_BIT = 4;
   localparam int ST_FAULT_BIT = 5;
   localparam int ST_TRIP_BIT = 6;
   localparam int ST_TRIPIN_BIT = 7;
   localparam int ST_LEVEL_LSB = 8;
   localparam int IRQ_W = 4;
   localparam int IRQ_TRIP = 0;
   localparam int IRQ_TEMP = 1;
   localparam int IRQ_RUN = 2;
   localparam int IRQ_DENY = 3;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ****************************************
   // types
   // ****************************************
   typedef enum {CLS_FREE, CLS_MON, CLS_GEN, CLS_NONE} bots_cls_e;
   typedef enum {BR_IDLE, BR_DELAY, BR_ON, BR_LAG, BR_CUT} bots_br_e;

   typedef struct packed {
      logic seq_en;
      logic [NUM_BRANCH-1:0] trip_en;
      logic [NUM_BRANCH-1:0] test_on;
   } bots_ctrl_s;

   typedef struct packed {
      logic [DLY_W-1:0] on_delay;
      logic [DLY_W-1:0] off_lag;
   } bots_timing_s;

endpackage

// file: bots_top.sv
// branch output trip sequencer with AXI4-Lite register slave
// Function
// - external trip input cuts every branch whose external trip enable is set
// - each branch has its own trip enable; disabled branches stay connected
// - with shutdown sequence set, an enabled branch disconnects after its own lag
// - each of four branches has its own startup connection delay
// - over-temperature output goes low when temperature exceeds its set value
// - run-time threshold resets to zero and zero never raises the alarm
// - level 0 lets every parameter be read and written
// - level 1 allows only monitor parameters, read and write
// - level 2 allows only reads of monitor parameters
// - protection level is 1 after reset
// - host reads settings, issues commands and changes level over the port
// - fault alarm output goes low when run time passes a nonzero threshold
//
// Implementation choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
module bots_top
   import bots_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYCLES_DEF
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic external_trip_input,
   input wire logic self_test_done,
   input wire logic [7:0] temp_meas,
   input wire logic [15:0] run_time,
   output logic [NUM_BRANCH-1:0] branch_out,
   output logic over_temp_output,
   output logic fault_alarm_output,
   output logic trip_alarm_output,
   output logic irq
);

   localparam int TICK_W = $clog2(TICK_CYCLES + 1);

   // ****************************************
   // decode helpers
   // ****************************************
   function automatic bots_cls_e addr_class(input logic [ADDR_W-1:0] a);
      bots_cls_e c;
      c = CLS_NONE;
      if (a[1:0] == 2'h0) begin
         if (a == OFS_PROT || a == OFS_STATUS || a == OFS_IRQ_STAT || a == OFS_IRQ_CLR
             || a == OFS_IRQ_EN) begin
            c = CLS_FREE;
         end else if (a == OFS_TEMP_SET || a == OFS_RUN_THR) begin
            c = CLS_MON;
         end else if (a == OFS_CTRL || a[7:4] == OFS_ON_DLY[7:4]
                      || a[7:4] == OFS_OFF_LAG[7:4]) begin
            c = CLS_GEN;
         end
      end
      return c;
   endfunction

   function automatic logic access_ok(input bots_cls_e c, input logic [1:0] lvl,
                                      input logic is_wr);
      logic ok;
      ok = 1'b0;
      case (c)
         CLS_FREE: ok = 1'b1;
         CLS_MON: ok = (lvl < PROT_MAX) || !is_wr;
         CLS_GEN: ok = (lvl == 2'h0);
         default: ok = 1'b0;
      endcase
      return ok;
   endfunction

   function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return r;
   endfunction

   // ****************************************
   // AXI4-Lite write channel
   // ****************************************
   logic aw_have_reg, w_have_reg;
   logic [ADDR_W-1:0] aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic wr_do, wr_ok;
   bots_cls_e wr_cls;
   logic [1:0] prot_reg;

   assign s_axi_awready = !aw_have_reg && !s_axi_bvalid;
   assign s_axi_wready = !w_have_reg && !s_axi_bvalid;
   assign wr_do = aw_have_reg && w_have_reg && !s_axi_bvalid;
   assign wr_cls = addr_class(aw_addr_reg);
   assign wr_ok = access_ok(wr_cls, prot_reg, 1'b1)
      && !(aw_addr_reg == OFS_PROT && w_strb_reg[0] && w_data_reg[1:0] > PROT_MAX);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_reg <= 1'b0;
         w_have_reg <= 1'b0;
         aw_addr_reg <= '0;
         w_data_reg <= 32'h00000000;
         w_strb_reg <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (wr_do) begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ****************************************
   // configuration registers
   // ****************************************
   bots_ctrl_s ctrl_reg;
   logic [7:0] temp_set_reg;
   logic [15:0] run_thr_reg;
   bots_timing_s tim_reg [NUM_BRANCH];
   logic [IRQ_W-1:0] irq_en_reg;
   logic [31:0] cur_word;
   logic [1:0] wr_idx;

   assign wr_idx = aw_addr_reg[3:2];
   assign cur_word = 32'(prot_reg) << ST_LEVEL_LSB;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prot_reg <= PROT_RST;
      end else if (wr_do && wr_ok && aw_addr_reg == OFS_PROT && w_strb_reg[0]) begin
         prot_reg <= w_data_reg[1:0];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_reg <= '0;
         temp_set_reg <= TEMP_SET_RST;
         run_thr_reg <= RUN_THR_RST;
         irq_en_reg <= '0;
      end else if (wr_do && wr_ok) begin
         if (aw_addr_reg == OFS_CTRL) begin
            ctrl_reg <= bots_ctrl_s'(9'(wmerge({23'h000000, ctrl_reg}, w_data_reg,
                                                w_strb_reg)));
         end
         if (aw_addr_reg == OFS_TEMP_SET && w_strb_reg[0]) begin
            temp_set_reg <= w_data_reg[7:0];
         end
         if (aw_addr_reg == OFS_RUN_THR) begin
            run_thr_reg <= 16'(wmerge({16'h0000, run_thr_reg}, w_data_reg, w_strb_reg));
         end
         if (aw_addr_reg == OFS_IRQ_EN && w_strb_reg[0]) begin
            irq_en_reg <= w_data_reg[IRQ_W-1:0];
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < NUM_BRANCH; i++) begin
            tim_reg[i] <= '{on_delay: DLY_RST, off_lag: DLY_RST};
         end
      end else if (wr_do && wr_ok && wr_cls == CLS_GEN) begin
         if (aw_addr_reg[7:4] == OFS_ON_DLY[7:4]) begin
            tim_reg[wr_idx].on_delay <= 16'(wmerge({16'h0000, tim_reg[wr_idx].on_delay},
                                                   w_data_reg, w_strb_reg));
         end
         if (aw_addr_reg[7:4] == OFS_OFF_LAG[7:4]) begin
            tim_reg[wr_idx].off_lag <= 16'(wmerge({16'h0000, tim_reg[wr_idx].off_lag},
                                                  w_data_reg, w_strb_reg));
         end
      end
   end

   // ****************************************
   // branch sequencers
   // ****************************************
   logic [TICK_W-1:0] tick_cnt_reg;
   logic tick;
   logic [NUM_BRANCH-1:0] cut_vec, cut_evt_vec;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tick_cnt_reg <= '0;
      end else if (tick) begin
         tick_cnt_reg <= '0;
      end else begin
         tick_cnt_reg <= tick_cnt_reg + TICK_W'(1);
      end
   end
   assign tick = (tick_cnt_reg == TICK_W'(TICK_CYCLES - 1));

   for (genvar g = 0; g < NUM_BRANCH; g++) begin : g_branch
      bots_branch u_branch (
         .aclk(aclk),
         .aresetn(aresetn),
         .tick(tick),
         .start(self_test_done),
         .test_on(ctrl_reg.test_on[g]),
         .trip_en(ctrl_reg.trip_en[g]),
         .seq_en(ctrl_reg.seq_en),
         .trip(external_trip_input),
         .timing(tim_reg[g]),
         .connected(branch_out[g]),
         .cut(cut_vec[g]),
         .cut_evt(cut_evt_vec[g])
      );
   end

   // ****************************************
   // monitor outputs
   // ****************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         over_temp_output <= 1'b1;
      end else if (temp_meas > temp_set_reg) begin
         over_temp_output <= 1'b0;
      end else if ({1'b0, temp_meas} + {1'b0, TEMP_HYST} <= {1'b0, temp_set_reg}) begin
         over_temp_output <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fault_alarm_output <= 1'b1;
      end else begin
         // zero threshold means the maintenance alarm is switched off
         fault_alarm_output <= !(run_thr_reg != RUN_THR_RST && run_time > run_thr_reg);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         trip_alarm_output <= 1'b1;
      end else begin
         trip_alarm_output <= !(|cut_vec);
      end
   end

   // ****************************************
   // interrupts
   // ****************************************
   logic [IRQ_W-1:0] irq_stat_reg, irq_set, irq_clr;
   logic rd_deny;

   assign irq_set[IRQ_TRIP] = |cut_evt_vec;
   assign irq_set[IRQ_TEMP] = (temp_meas > temp_set_reg) && over_temp_output;
   assign irq_set[IRQ_RUN] = (run_thr_reg != RUN_THR_RST && run_time > run_thr_reg)
      && fault_alarm_output;
   assign irq_set[IRQ_DENY] = (wr_do && !wr_ok) || rd_deny;
   assign irq_clr = (wr_do && aw_addr_reg == OFS_IRQ_CLR && w_strb_reg[0]) ?
      w_data_reg[IRQ_W-1:0] : '0;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_stat_reg <= '0;
      end else begin
         // a new event in the clearing cycle survives the clear
         irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
      end
   end
   assign irq = |(irq_stat_reg & irq_en_reg);

   // ****************************************
   // AXI4-Lite read channel
   // ****************************************
   bots_cls_e rd_cls;
   logic [31:0] rd_word;

   assign s_axi_arready = !s_axi_rvalid;
   assign rd_cls = addr_class(s_axi_araddr);
   assign rd_deny = s_axi_arvalid && s_axi_arready && !access_ok(rd_cls, prot_reg, 1'b0);

   always_comb begin
      rd_word = 32'h00000000;
      case (s_axi_araddr)
         OFS_CTRL: rd_word = {23'h000000, ctrl_reg};
         OFS_PROT: rd_word = {30'h00000000, prot_reg};
         OFS_TEMP_SET: rd_word = {24'h000000, temp_set_reg};
         OFS_RUN_THR: rd_word = {16'h0000, run_thr_reg};
         OFS_STATUS: begin
            rd_word = cur_word;
            rd_word[NUM_BRANCH-1:0] = branch_out;
            rd_word[ST_TEMP_BIT] = over_temp_output;
            rd_word[ST_FAULT_BIT] = fault_alarm_output;
            rd_word[ST_TRIP_BIT] = trip_alarm_output;
            rd_word[ST_TRIPIN_BIT] = external_trip_input;
         end
         OFS_IRQ_STAT: rd_word = {28'h0000000, irq_stat_reg};
         OFS_IRQ_EN: rd_word = {28'h0000000, irq_en_reg};
         default: begin
            if (rd_cls == CLS_GEN && s_axi_araddr[7:4] == OFS_ON_DLY[7:4]) begin
               rd_word = {16'h0000, tim_reg[s_axi_araddr[3:2]].on_delay};
            end else if (rd_cls == CLS_GEN) begin
               rd_word = {16'h0000, tim_reg[s_axi_araddr[3:2]].off_lag};
            end
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_deny ? 32'h00000000 : rd_word;
         s_axi_rresp <= rd_deny ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   for (genvar g = 0; g < NUM_BRANCH; g++) begin : g_chk
      property p_trip_cut;
         branch_out[g] && external_trip_input && ctrl_reg.trip_en[g] && !ctrl_reg.seq_en
         |=> !branch_out[g];
      endproperty
      a_trip_cut: assert property (p_trip_cut) else $error("enabled branch not cut");

      property p_trip_disabled;
         branch_out[g] && !ctrl_reg.trip_en[g] && ctrl_reg.test_on[g]
         |=> branch_out[g];
      endproperty
      a_trip_disabled: assert property (p_trip_disabled) else $error("disabled branch cut");

      property p_lag_hold;
         // only the trip edge: once the lag runs out the branch is meant to drop
         branch_out[g] && $rose(external_trip_input) && ctrl_reg.trip_en[g] && ctrl_reg.seq_en
         && ctrl_reg.test_on[g] && tim_reg[g].off_lag != DLY_RST |=> branch_out[g];
      endproperty
      a_lag_hold: assert property (p_lag_hold) else $error("lagged branch cut at once");

      property p_connect_cause;
         $rose(branch_out[g]) |-> $past(ctrl_reg.test_on[g]) && $past(self_test_done, 2);
      endproperty
      a_connect_cause: assert property (p_connect_cause) else $error("bad connect");

      property p_stay_cut;
         !branch_out[g] && external_trip_input && ctrl_reg.trip_en[g] |=> !branch_out[g];
      endproperty
      a_stay_cut: assert property (p_stay_cut) else $error("cut branch reconnected");
   end

   property p_over_temp;
      temp_meas > temp_set_reg |=> !over_temp_output;
   endproperty
   a_over_temp: assert property (p_over_temp) else $error("over-temp not flagged");

   property p_run_zero;
      run_thr_reg == RUN_THR_RST |=> fault_alarm_output;
   endproperty
   a_run_zero: assert property (p_run_zero) else $error("alarm with zero threshold");

   property p_run_alarm;
      run_thr_reg != RUN_THR_RST && run_time > run_thr_reg |=> !fault_alarm_output;
   endproperty
   a_run_alarm: assert property (p_run_alarm) else $error("run-time alarm missed");

   property p_level0;
      wr_do && prot_reg == 2'h0 && wr_cls == CLS_GEN |=> s_axi_bvalid && s_axi_bresp == RESP_OKAY;
   endproperty
   a_level0: assert property (p_level0) else $error("level 0 write refused");

   property p_level1;
      wr_do && prot_reg == 2'h1 && wr_cls == CLS_GEN
      |=> s_axi_bvalid && s_axi_bresp == RESP_SLVERR && $stable(ctrl_reg);
   endproperty
   a_level1: assert property (p_level1) else $error("level 1 allowed general write");

   property p_level2;
      wr_do && prot_reg == PROT_MAX && wr_cls == CLS_MON
      |=> s_axi_bresp == RESP_SLVERR && $stable(temp_set_reg) && $stable(run_thr_reg);
   endproperty
   a_level2: assert property (p_level2) else $error("level 2 accepted a write");

   property p_prot_reset;
      !$past(aresetn) |-> prot_reg == PROT_RST;
   endproperty
   a_prot_reset: assert property (p_prot_reset) else $error("level not 1 after reset");

   property p_read_answer;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_read_answer: assert property (p_read_answer) else $error("read not answered");

   c_trip: cover property (external_trip_input && |cut_evt_vec);
   c_lag: cover property (ctrl_reg.seq_en && branch_out[0] && external_trip_input);
   c_deny: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
   c_irq: cover property ($rose(irq));

endmodule // bots_top

// file: bots_top_tb.sv
// self-checking testbench of the branch output trip sequencer
`timescale 1ns/100ps
module bots_top_tb import bots_pkg::*;;
   logic aclk = 1'b0, aresetn = 1'b0, treq = 1'b0, rreq = 1'b0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, temp_meas = 8'h20, v;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [15:0] run_time = 16'h0000;
   logic [7:0] lfsr = 8'h49;
   wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
   wire logic [1:0] s_axi_bresp, s_axi_rresp;
   wire logic [31:0] s_axi_rdata;
   wire logic [3:0] branch_out;
   wire logic external_trip_input, self_test_done, over_temp_output;
   wire logic fault_alarm_output, trip_alarm_output;
   int bad_count = 0;
   int comparisons = 0;
   logic [1:0] qw[$];
   logic [33:0] qr[$];
   // four-cycle tick keeps delay and lag times within a few dozen cycles
   bots_top #(.TICK_CYCLES(4)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .external_trip_input,
      .self_test_done, .temp_meas, .run_time, .branch_out, .over_temp_output,
      .fault_alarm_output, .trip_alarm_output, .irq);
   bots_trip_src src (.aclk, .trip_req(treq), .ready_req(rreq), .external_trip_input,
      .self_test_done);
   // ****************************************
   // helpers
   // ****************************************
   initial forever #5 aclk = ~aclk;
   function automatic logic [7:0] lfsr_next(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic print_verdict();
      if (bad_count == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic cmp(input string nm, input logic [33:0] e, input logic [33:0] s);
      comparisons++;
      if (s !== e) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] r);
      int n;
      logic done;
      done = 1'b0;
      @(posedge aclk);
      if (w) qw.push_back(r);
      else qr.push_back({d, r});
      s_axi_awaddr <= a;
      s_axi_araddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= w;
      s_axi_wvalid <= w;
      s_axi_bready <= w;
      s_axi_arvalid <= !w;
      s_axi_rready <= !w;
      for (n = 0; n < 50 && !done; n++) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if ((s_axi_bvalid && w) || (s_axi_rvalid && !w)) done = 1'b1;
      end
      s_axi_bready <= 1'b0;
      s_axi_rready <= 1'b0;
      if (!done) begin
         bad_count++;
         print_verdict();
      end
   endtask
   // ****************************************
   // result watcher
   // ****************************************
   always @(posedge aclk) begin
      if (s_axi_bvalid && s_axi_bready && qw.size() > 0) cmp("bresp", {32'h0, qw.pop_front()},
         {32'h0, s_axi_bresp});
      if (s_axi_rvalid && s_axi_rready && qr.size() > 0) cmp("read", qr.pop_front(),
         {s_axi_rdata, s_axi_rresp});
   end
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      lfsr = lfsr_next(lfsr);
      v = {1'b1, lfsr[6:1], 1'b0};
      bus(0, OFS_PROT, 32'h1, RESP_OKAY);
      bus(0, OFS_RUN_THR, 32'h0, RESP_OKAY);
      bus(1, OFS_CTRL, 32'h3F, RESP_SLVERR);
      bus(1, OFS_TEMP_SET, {24'h0, v}, RESP_OKAY);
      bus(1, OFS_PROT, 32'h2, RESP_OKAY);
      bus(1, OFS_RUN_THR, 32'h5, RESP_SLVERR);
      bus(0, OFS_TEMP_SET, {24'h0, v}, RESP_OKAY);
      bus(1, OFS_PROT, 32'h0, RESP_OKAY);
      bus(1, OFS_CTRL, 32'h3F, RESP_OKAY);
      bus(1, OFS_ON_DLY + 8'h0C, 32'h5, RESP_OKAY);
      repeat (20) @(posedge aclk);
      bus(0, OFS_STATUS, 32'h70, RESP_OKAY);
      rreq <= 1'b1;
      // partner stage, then idle to delay, then delay to connected
      repeat (3) @(posedge aclk);
      bus(0, OFS_STATUS, 32'h77, RESP_OKAY);
      repeat (30) @(posedge aclk);
      bus(0, OFS_STATUS, 32'h7F, RESP_OKAY);
      bus(1, OFS_IRQ_EN, 32'h1, RESP_OKAY);
      treq <= 1'b1;
      repeat (10) @(posedge aclk);
      bus(0, OFS_STATUS, 32'hBC, RESP_OKAY);
      cmp("irq", 34'h1, {33'h0, irq});
      cmp("pins", 34'h066, {27'h0, branch_out, over_temp_output, fault_alarm_output,
         trip_alarm_output});
      bus(1, OFS_IRQ_EN, 32'h0, RESP_OKAY);
      cmp("irq", 34'h0, {33'h0, irq});
      bus(1, OFS_IRQ_EN, 32'h1, RESP_OKAY);
      treq <= 1'b0;
      bus(1, OFS_IRQ_CLR, 32'h1, RESP_OKAY);
      cmp("irq", 34'h0, {33'h0, irq});
      // lag of six ticks on branch 0 only, so branch 1 marks the trip edge
      bus(1, OFS_OFF_LAG, 32'h6, RESP_OKAY);
      bus(1, OFS_CTRL, 32'h13F, RESP_OKAY);
      repeat (30) @(posedge aclk);
      treq <= 1'b1;
      // let the cut and the trip alarm settle before the status is taken
      repeat (3) @(posedge aclk);
      bus(0, OFS_STATUS, 32'hBD, RESP_OKAY);
      repeat (40) @(posedge aclk);
      bus(0, OFS_STATUS, 32'hBC, RESP_OKAY);
      treq <= 1'b0;
      repeat (40) @(posedge aclk);
      temp_meas <= v + 8'h01;
      run_time <= 16'hFFFF;
      repeat (3) @(posedge aclk);
      bus(0, OFS_STATUS, 32'h6F, RESP_OKAY);
      bus(1, OFS_RUN_THR, 32'hA, RESP_OKAY);
      bus(0, OFS_STATUS, 32'h4F, RESP_OKAY);
      cmp("pins", 34'h079, {27'h0, branch_out, over_temp_output, fault_alarm_output,
         trip_alarm_output});
      bus(0, 8'hFC, 32'h0, RESP_SLVERR);
      // one more edge so the watcher takes the last answer before the verdict
      @(posedge aclk);
      print_verdict();
   end
endmodule // bots_top_tb

// file: bots_trip_src.sv
// behavioural source of the trip request and power-on check signals
`timescale 1ns/100ps
module bots_trip_src (
   input wire logic aclk,
   input wire logic trip_req,
   input wire logic ready_req,
   output logic external_trip_input,
   output logic self_test_done
);
   initial begin
      external_trip_input = 1'b0;
      self_test_done = 1'b0;
   end
   // registered so both levels move just after an edge, never on it
   always @(posedge aclk) begin
      external_trip_input <= trip_req;
      self_test_done <= ready_req;
   end
endmodule // bots_trip_src
